// ===== hdl/tml_lookup.sv
`timescale 1ns/1ps
// Summary of operation
// - core reset synchronous active high, held at least 100 cycles
// - requests sampled and results driven on the core clock
// - fully pipelined, a new request may enter every cycle
// - result_strobe follows its request after a fixed pipeline depth
// - one result cycle per request, echoing the accepted key
// - result_hit set on any match, with the entry payload
// - matching entry address shown with result_strobe
// - on a miss payload and index carry no meaning
// - lowest matching address wins, with its payload
// - key, payload and depth are compile-time parameters
// - use_block_memory picks distributed or block payload storage
// - zero to two range subfields; zero means pure ternary
// - range width 2 to 16 bits, shared by both subfields
// - range subfields adjacent, second above first, from range_field_position
// - range data is lower bound, range mask is upper bound
// - result_entry_index is log2 of depth bits wide
module tml_lookup import tml_pkg::*; #(
    parameter int search_width_param = TML_KEY_W,
    parameter int payload_size_param = TML_PAY_W,
    parameter int entry_count_param = TML_DEPTH,
    parameter int use_block_memory = TML_USE_USE_BLOCK_MEMORY,
    parameter int range_field_count = TML_RNG_CNT,
    parameter int range_field_width = TML_RNG_W,
    parameter int range_field_position = TML_RNG_POS,
    localparam int K = search_width_param,
    localparam int V = payload_size_param,
    localparam int D = entry_count_param,
    localparam int IW = (D > 1) ? $clog2(D) : 1
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic query_strobe,
    input wire logic [K-1:0] query_key,
    output logic query_ready,
    input wire logic result_ready,
    output logic result_strobe,
    output logic [K-1:0] result_key_echo,
    output logic result_hit,
    output logic result_match_flag,
    output logic [IW-1:0] result_entry_index,
    output logic [V-1:0] result_payload,
    input wire logic prog_en,
    input wire logic [IW-1:0] prog_addr,
    input wire logic prog_valid,
    input wire logic [K-1:0] prog_data,
    input wire logic [K-1:0] prog_mask,
    input wire logic [V-1:0] prog_payload
);

    // key bits that take part in range compares rather than ternary compares
    localparam logic [K-1:0] RNG_BITS =
        (~({K{1'b1}} << (range_field_count * range_field_width))) << range_field_position;
    localparam int RP0 = range_field_position;
    localparam int RP1 = range_field_position + range_field_width;
    localparam int RW = range_field_width;

    typedef struct packed {
        logic [K-1:0] key;
        logic hit;
        logic [IW-1:0] idx;
        logic [V-1:0] pay;
    } tml_rslt_t;

    // entry store: data and mask in flops so every entry compares in parallel
    logic [K-1:0] ent_data_q [D];
    logic [K-1:0] ent_mask_q [D];
    logic [D-1:0] ent_vld_q;

    logic adv;
    logic v1_q, v1_d, v2_q, v2_d, v3_q, v3_d;
    logic [K-1:0] key1_q, key1_d, key2_q, key2_d, key3_q, key3_d;
    logic [D-1:0] mvec_d, mvec_q;
    logic hit3_q, hit3_d;
    logic [IW-1:0] idx3_q, idx3_d;
    logic pe_hit;
    logic [IW-1:0] pe_idx;
    logic [V-1:0] pay_s3;

    tml_rslt_t buf_q [2];
    tml_rslt_t buf_d [2];
    logic wp_q, wp_d, rp_q, rp_d;
    logic [1:0] cnt_q, cnt_d;
    logic push, pop;

    // the pipe waits when ce is low or the result buffer is full; with result_ready held high the buffer never fills
    assign adv = ce && (cnt_q != TML_BUF_FULL);
    assign query_ready = adv;

    // entry writes; valid bits clear under reset so no stale entry can hit
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ent_vld_q <= '0;
        end else if (ce && prog_en && (int'(prog_addr) < D)) begin
            ent_vld_q[prog_addr] <= prog_valid;
        end
        if (ce && prog_en && (int'(prog_addr) < D)) begin
            ent_data_q[prog_addr] <= prog_data;
            ent_mask_q[prog_addr] <= prog_mask;
        end
    end

    // one comparator per entry, fed from stage one so the match vector sits beside
    // the stage-two key and the encoded verdict lands beside the stage-three key
    for (genvar e = 0; e < D; e++) begin : g_ent
        logic r0_ok;
        logic r1_ok;
        logic tern_ok;
        // mask bit high means the key bit is ignored
        assign tern_ok = ((key1_q ^ ent_data_q[e]) & ~ent_mask_q[e] & ~RNG_BITS) == '0;
        if (range_field_count > 0) begin : g_r0
            // data holds the lower bound, mask the upper bound
            assign r0_ok = (key1_q[RP0 +: RW] >= ent_data_q[e][RP0 +: RW]) &&
                           (key1_q[RP0 +: RW] <= ent_mask_q[e][RP0 +: RW]);
        end else begin : g_nr0
            assign r0_ok = 1'b1;
        end
        if (range_field_count > 1) begin : g_r1
            assign r1_ok = (key1_q[RP1 +: RW] >= ent_data_q[e][RP1 +: RW]) &&
                           (key1_q[RP1 +: RW] <= ent_mask_q[e][RP1 +: RW]);
        end else begin : g_nr1
            assign r1_ok = 1'b1;
        end
        assign mvec_d[e] = ent_vld_q[e] && tern_ok && r0_ok && r1_ok;
    end

    // priority encoder: walk downward so the lowest set index is the last write
    always_comb begin
        pe_hit = 1'b0;
        pe_idx = '0;
        for (int i = D - 1; i >= 0; i--) begin
            if (mvec_q[i]) begin
                pe_hit = 1'b1;
                pe_idx = IW'(i);
            end
        end
    end

    // payload storage style; both styles give the same latency
    if (use_block_memory != 0) begin : g_use_block_memory
        logic [V-1:0] pay_mem [D];
        logic [V-1:0] pay_rd_q;
        // synchronous read fits a block memory port
        always_ff @(posedge mclk) begin
            if (ce && prog_en && (int'(prog_addr) < D)) begin
                pay_mem[prog_addr] <= prog_payload;
            end
            if (adv) begin
                pay_rd_q <= pay_mem[pe_idx];
            end
        end
        assign pay_s3 = pay_rd_q;
    end else begin : g_lut
        logic [V-1:0] pay_mem [D];
        // asynchronous read maps to distributed memory
        always_ff @(posedge mclk) begin
            if (ce && prog_en && (int'(prog_addr) < D)) begin
                pay_mem[prog_addr] <= prog_payload;
            end
        end
        assign pay_s3 = pay_mem[idx3_q];
    end

    // pipeline next state: sample, compare, encode
    always_comb begin
        v1_d = v1_q;
        key1_d = key1_q;
        v2_d = v2_q;
        key2_d = key2_q;
        v3_d = v3_q;
        key3_d = key3_q;
        hit3_d = hit3_q;
        idx3_d = idx3_q;
        if (adv) begin
            v1_d = query_strobe;
            key1_d = query_key;
            v2_d = v1_q;
            key2_d = key1_q;
            v3_d = v2_q;
            key3_d = key2_q;
            hit3_d = pe_hit;
            idx3_d = pe_idx;
        end
    end

    // pipeline registers; reset clears the valid chain, keys, match vector and verdict
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            v1_q <= 1'b0;
            v2_q <= 1'b0;
            v3_q <= 1'b0;
            key1_q <= '0;
            key2_q <= '0;
            key3_q <= '0;
            mvec_q <= '0;
            hit3_q <= 1'b0;
            idx3_q <= '0;
        end else begin
            v1_q <= v1_d;
            v2_q <= v2_d;
            v3_q <= v3_d;
            key1_q <= key1_d;
            key2_q <= key2_d;
            key3_q <= key3_d;
            mvec_q <= adv ? mvec_d : mvec_q;
            hit3_q <= hit3_d;
            idx3_q <= idx3_d;
        end
    end

    // two-entry result buffer: a receiver stall holds the pipe instead of losing a result
    assign push = adv && v3_q;
    assign pop = ce && (cnt_q != TML_CNT_ZERO) && result_ready;

    always_comb begin
        buf_d = buf_q;
        wp_d = wp_q;
        rp_d = rp_q;
        cnt_d = cnt_q;
        if (push) begin
            buf_d[wp_q] = '{key: key3_q, hit: hit3_q, idx: idx3_q, pay: pay_s3};
            wp_d = ~wp_q;
        end
        if (pop) begin
            rp_d = ~rp_q;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + TML_CNT_ONE;
        end else if (pop && !push) begin
            cnt_d = cnt_q - TML_CNT_ONE;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            buf_q[0] <= '0;
            buf_q[1] <= '0;
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            cnt_q <= TML_CNT_ZERO;
        end else begin
            buf_q <= buf_d;
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    // result port; on a miss the encoder gives index 0, so the payload is that of entry 0
    assign result_strobe = (cnt_q != TML_CNT_ZERO);
    assign result_key_echo = buf_q[rp_q].key;
    assign result_hit = buf_q[rp_q].hit;
    assign result_match_flag = buf_q[rp_q].hit;
    assign result_entry_index = buf_q[rp_q].idx;
    assign result_payload = buf_q[rp_q].pay;

    // helper: match vector that produced the stage-3 verdict
    logic [D-1:0] mvec3_h;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            mvec3_h <= '0;
        end else if (adv) begin
            mvec3_h <= mvec_q;
        end
    end

    AST_LATENCY: assert property (@(posedge mclk) disable iff (sys_rst)
        (adv && query_strobe) ##1 adv ##1 adv |=> v3_q)
        else $error("result not ready three advances after request");

    AST_ECHO_KEY: assert property (@(posedge mclk) disable iff (sys_rst)
        (adv && query_strobe) ##1 adv ##1 adv |=> (key3_q == $past(query_key, 3)))
        else $error("echoed key differs from accepted key");

    AST_HIT_ANY: assert property (@(posedge mclk) disable iff (sys_rst)
        adv |=> (hit3_q == (|$past(mvec_q))))
        else $error("hit flag disagrees with match vector");

    AST_INDEX_SET: assert property (@(posedge mclk) disable iff (sys_rst)
        hit3_q |-> mvec3_h[idx3_q])
        else $error("reported index is not a matching entry");

    AST_LOWEST_WINS: assert property (@(posedge mclk) disable iff (sys_rst)
        hit3_q |-> ((mvec3_h & ~({D{1'b1}} << idx3_q)) == '0))
        else $error("a lower matching entry was passed over");

    AST_MISS_EMPTY: assert property (@(posedge mclk) disable iff (sys_rst)
        (v3_q && !hit3_q) |-> (mvec3_h == '0))
        else $error("miss reported although an entry matched");

    AST_RESET_QUIET: assert property (@(posedge mclk)
        sys_rst |=> (!result_strobe && !v1_q && !v3_q))
        else $error("pipeline not cleared by reset");

    AST_NO_STALL: assert property (@(posedge mclk) disable iff (sys_rst)
        (ce && $past(ce) && $past(result_ready) && result_ready) |-> query_ready)
        else $error("request refused while receiver is ready");

    AST_BUF_BOUND: assert property (@(posedge mclk) disable iff (sys_rst)
        (cnt_q == TML_BUF_FULL) |-> !push)
        else $error("push into full result buffer");

    CVR_HIT: cover property (@(posedge mclk) disable iff (sys_rst) result_strobe && result_hit);
    CVR_MISS: cover property (@(posedge mclk) disable iff (sys_rst) result_strobe && !result_hit);
    CVR_BACK2BACK: cover property (@(posedge mclk) disable iff (sys_rst) result_strobe [*3]);
    CVR_FULL: cover property (@(posedge mclk) disable iff (sys_rst) cnt_q == TML_BUF_FULL);

endmodule // tml_lookup

// ===== pkg/tml_pkg.sv
package tml_pkg;
    // default shape of one lookup engine
    localparam int TML_KEY_W = 32;
    localparam int TML_PAY_W = 16;
    localparam int TML_DEPTH = 16;
    localparam int TML_USE_USE_BLOCK_MEMORY = 0;
    localparam int TML_RNG_CNT = 1;
    localparam int TML_RNG_W = 16;
    localparam int TML_RNG_POS = 0;
    // reset must be held this long so the pipeline drains
    localparam int TML_RST_MIN_CYC = 100;
    // request to buffer entry, in cycles of advance
    localparam int TML_PIPE_DEPTH = 3;
    // result buffer occupancy codes
    localparam logic [1:0] TML_CNT_ZERO = 2'h0;
    localparam logic [1:0] TML_CNT_ONE = 2'h1;
    localparam logic [1:0] TML_BUF_FULL = 2'h2;
endpackage

// ===== verif/tml_sink.sv
`timescale 1ns/1ps
// result receiver: holds ready low while stalled, or every other cycle when slow
module tml_sink import tml_pkg::*; (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic stall,
    input wire logic slow,
    output logic result_ready
);
    logic ph_q;
    logic ph_d;
    // phase toggle makes slow mode a one-in-two acceptor
    always_comb begin
        ph_d = ~ph_q;
    end
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ph_q <= 1'b0;
        end else begin
            ph_q <= ph_d;
        end
    end
    assign result_ready = !stall && !(slow && ph_q);
endmodule // tml_sink

// ===== verif/ternary_match_lookup_pipeline_tb_top.sv
`timescale 1ns/1ps
// stimulus, reference table and result checks for the lookup engine
module ternary_match_lookup_pipeline_tb_top import tml_pkg::*;;
    localparam int K = 32;
    localparam int V = 16;
    localparam int D = 16;
    localparam int IW = 4;
    // second engine: block payload store and two narrow range subfields
    localparam int NR2 = 2;
    localparam int RW2 = 8;
    typedef struct packed {logic [K-1:0] k; logic h; logic [IW-1:0] i; logic [V-1:0] p;} tml_exp_t;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic ce = 1'b1;
    logic query_strobe = 1'b0;
    logic [K-1:0] query_key = '0;
    logic query_ready, result_ready, result_strobe, result_hit, result_match_flag;
    logic [K-1:0] result_key_echo;
    logic [IW-1:0] result_entry_index;
    logic [V-1:0] result_payload;
    logic query_ready_b, result_strobe_b, result_hit_b, result_match_flag_b;
    logic [K-1:0] result_key_echo_b;
    logic [IW-1:0] result_entry_index_b;
    logic [V-1:0] result_payload_b;
    logic prog_en = 1'b0;
    logic prog_valid = 1'b0;
    logic [IW-1:0] prog_addr = '0;
    logic [K-1:0] prog_data = '0;
    logic [K-1:0] prog_mask = '0;
    logic [V-1:0] prog_payload = '0;
    logic stall = 1'b0;
    logic slow = 1'b0;
    logic saw_full = 1'b0;
    logic steady = 1'b0;
    int failures = 0;
    int total_checks = 0;
    int cyc = 0;
    int lat = -1;
    logic e_v [D];
    logic [K-1:0] e_d [D];
    logic [K-1:0] e_m [D];
    logic [V-1:0] e_p [D];
    tml_exp_t exp_q [$];
    tml_exp_t exp2_q [$];
    int t_q [$];
    logic [K-1:0] keys [8] = '{32'h1234_0090, 32'h1234_0100, 32'h5555_0100, 32'h5555_0101,
                               32'h5555_007F, 32'h5555_0080, 32'hABC7_FFFF, 32'hABD0_0000};

    always #2.5 mclk = ~mclk;
    always @(posedge mclk) cyc <= cyc + 1;

    tml_lookup #(.search_width_param(K), .payload_size_param(V), .entry_count_param(D)) i_dut (
        .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .query_strobe(query_strobe), .query_key(query_key),
        .query_ready(query_ready), .result_ready(result_ready), .result_strobe(result_strobe),
        .result_key_echo(result_key_echo), .result_hit(result_hit), .result_match_flag(result_match_flag),
        .result_entry_index(result_entry_index), .result_payload(result_payload), .prog_en(prog_en),
        .prog_addr(prog_addr), .prog_valid(prog_valid), .prog_data(prog_data), .prog_mask(prog_mask),
        .prog_payload(prog_payload));
    tml_sink i_sink (.mclk(mclk), .sys_rst(sys_rst), .stall(stall), .slow(slow), .result_ready(result_ready));
    tml_lookup #(.search_width_param(K), .payload_size_param(V), .entry_count_param(D), .use_block_memory(1),
        .range_field_count(NR2), .range_field_width(RW2)) i_dut_blk (
        .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .query_strobe(query_strobe), .query_key(query_key),
        .query_ready(query_ready_b), .result_ready(result_ready), .result_strobe(result_strobe_b),
        .result_key_echo(result_key_echo_b), .result_hit(result_hit_b), .result_match_flag(result_match_flag_b),
        .result_entry_index(result_entry_index_b), .result_payload(result_payload_b), .prog_en(prog_en),
        .prog_addr(prog_addr), .prog_valid(prog_valid), .prog_data(prog_data), .prog_mask(prog_mask),
        .prog_payload(prog_payload));

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            failures++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    // reference search for nr range subfields of w bits: walk downward so the lowest match is kept
    function automatic tml_exp_t ref_look(input logic [K-1:0] k, input int nr, input int w);
        tml_exp_t r;
        logic [K-1:0] rb;
        logic [K-1:0] fm;
        logic ok;
        r = '0;
        r.k = k;
        rb = ((K'(1) << (nr * w)) - K'(1)) << TML_RNG_POS;
        fm = (K'(1) << w) - K'(1);
        for (int n = D - 1; n >= 0; n--) begin
            ok = e_v[n] && ((k ^ e_d[n]) & ~e_m[n] & ~rb) == '0;
            for (int j = 0; j < nr; j++) begin
                ok = ok && ((k >> (TML_RNG_POS + j * w)) & fm) >= ((e_d[n] >> (TML_RNG_POS + j * w)) & fm)
                     && ((k >> (TML_RNG_POS + j * w)) & fm) <= ((e_m[n] >> (TML_RNG_POS + j * w)) & fm);
            end
            if (ok) begin
                r.h = 1'b1;
                r.i = IW'(n);
                r.p = e_p[n];
            end
        end
        return r;
    endfunction

    // one result word against its expectation; index and payload only matter on a hit
    task automatic cmp_result(input tml_exp_t e, input string who, input logic [K-1:0] k, input logic h,
                              input logic f, input logic [IW-1:0] i, input logic [V-1:0] p);
        check(k === e.k, {who, ": key echo"});
        check(h === e.h && f === e.h, {who, ": hit flag"});
        if (e.h) check(i === e.i && p === e.p, {who, ": index or payload"});
    endtask

    task automatic prog(input int a, input logic v, input logic [K-1:0] d, input logic [K-1:0] m,
                        input logic [V-1:0] p);
        @(posedge mclk);
        prog_en <= 1'b1;
        prog_addr <= IW'(a);
        prog_valid <= v;
        prog_data <= d;
        prog_mask <= m;
        prog_payload <= p;
        @(posedge mclk);
        prog_en <= 1'b0;
        e_v[a] = v;
        e_d[a] = d;
        e_m[a] = m;
        e_p[a] = p;
    endtask

    // request is held until an edge sees query_ready and query_ready_b both high
    task automatic query(input logic [K-1:0] k);
        int n;
        n = 0;
        query_strobe <= 1'b1;
        query_key <= k;
        do begin
            @(posedge mclk);
            n++;
        end while ((query_ready & query_ready_b) !== 1'b1 && n < 200);
        if (n >= 200) begin
            check(1'b0, "request never taken");
            print_verdict();
        end
        exp_q.push_back(ref_look(k, TML_RNG_CNT, TML_RNG_W));
        exp2_q.push_back(ref_look(k, NR2, RW2));
        t_q.push_back(steady ? cyc : -1);
    endtask

    task automatic drain();
        int n;
        query_strobe <= 1'b0;
        n = 0;
        while ((exp_q.size() > 0 || exp2_q.size() > 0) && n < 300) begin
            @(posedge mclk);
            n++;
        end
        check(exp_q.size() == 0, "result missing");
        check(exp2_q.size() == 0, "result missing, block store");
    endtask

    // result monitor: every popped word is matched against the reference
    always @(posedge mclk) begin : mon
        tml_exp_t e;
        int t;
        if (query_ready === 1'b0 && ce === 1'b1) saw_full <= 1'b1;
        if (sys_rst === 1'b0 && ce === 1'b1 && result_ready === 1'b1) begin
            if (result_strobe === 1'b1) begin
                check(exp_q.size() > 0, "extra result");
                if (exp_q.size() > 0) begin
                    e = exp_q.pop_front();
                    t = t_q.pop_front();
                    cmp_result(e, "distributed", result_key_echo, result_hit, result_match_flag,
                               result_entry_index, result_payload);
                    if (t >= 0 && lat < 0) lat = cyc - t;
                    if (t >= 0) check(cyc - t == lat && lat > 0, "latency not fixed");
                end
            end
            if (result_strobe_b === 1'b1) begin
                check(exp2_q.size() > 0, "extra result, block store");
                if (exp2_q.size() > 0) begin
                    e = exp2_q.pop_front();
                    cmp_result(e, "block", result_key_echo_b, result_hit_b, result_match_flag_b,
                               result_entry_index_b, result_payload_b);
                end
            end
        end
    end

    initial begin
        for (int n = 0; n < D; n++) e_v[n] = 1'b0;
        repeat (TML_RST_MIN_CYC) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        prog(0, 1'b1, 32'h1234_0000, 32'h0000_00FF, 16'hA000);
        prog(1, 1'b1, 32'h0000_0080, 32'hFFFF_0100, 16'hA001);
        prog(2, 1'b0, 32'h5555_0000, 32'h0000_FFFF, 16'hA002);
        prog(9, 1'b1, 32'hABC0_0000, 32'h000F_FFFF, 16'hA009);
        steady = 1'b1;
        for (int n = 0; n < 8; n++) query(keys[n]);
        drain();
        steady = 1'b0;
        $display("test back_to_back done");
        stall <= 1'b1;
        fork
            for (int n = 0; n < 8; n++) query(keys[n]);
            begin
                repeat (40) @(posedge mclk);
                stall <= 1'b0;
            end
        join
        drain();
        check(saw_full === 1'b1, "buffer never refused");
        $display("test stall_fill done");
        slow <= 1'b1;
        fork
            for (int n = 7; n >= 0; n--) query(keys[n]);
            begin
                repeat (3) @(posedge mclk);
                ce <= 1'b0;
                repeat (3) @(posedge mclk);
                ce <= 1'b1;
            end
        join
        drain();
        slow <= 1'b0;
        $display("test slow_sink done");
        query(keys[0]);
        query(keys[6]);
        sys_rst <= 1'b1;
        query_strobe <= 1'b0;
        @(posedge mclk);
        exp_q.delete();
        exp2_q.delete();
        t_q.delete();
        for (int n = 0; n < D; n++) e_v[n] = 1'b0;
        repeat (TML_RST_MIN_CYC) @(posedge mclk);
        #1;
        check(result_strobe === 1'b0 && query_ready === 1'b1, "reset state");
        @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        query(keys[0]);
        drain();
        $display("test mid_reset done");
        print_verdict();
    end
endmodule // ternary_match_lookup_pipeline_tb_top
